// ---- logic/uart_pkg.sv ----
// constants and types for the serial receiver and break transmitter
package uart_pkg;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_RXDATA  = 8'h08;
  localparam logic [7:0]  ADDR_TXDATA  = 8'h0c;
  localparam logic [7:0]  ADDR_BAUD    = 8'h10;
  localparam int          CTRL_SERIAL_PORT_ENABLE    = 0;
  localparam int          CTRL_RECEIVE_CONTINUOUS_ENABLE    = 1;
  localparam int          CTRL_SYNC    = 2;
  localparam int          CTRL_TRANSMIT_ENABLE    = 3;
  localparam int          CTRL_SEND_BREAK_REQUEST   = 4;
  localparam int          CTRL_NINE    = 5;
  localparam int          ST_RXIF      = 0;
  localparam int          ST_TXIF      = 1;
  localparam int          ST_TSE       = 2;
  localparam int          ST_OVERRUN   = 3;
  localparam int          ST_FERR      = 4;
  localparam int          ST_BIT9      = 5;
  localparam int          ST_SEND_BREAK_REQUEST     = 6;
  localparam logic [5:0]  CTRL_RESET   = 6'h00;
  localparam logic [15:0] BAUD_RESET   = 16'h0036;
  localparam logic [3:0]  TICK_LAST    = 4'hf;
  localparam logic [3:0]  HALF_BIT     = 4'h7;
  localparam logic [3:0]  MAJ_FIRST    = 4'hd;
  localparam logic [3:0]  MAJ_SECOND   = 4'he;
  localparam logic [3:0]  LAST_BIT_8   = 4'h7;
  localparam logic [3:0]  LAST_BIT_9   = 4'h8;
  localparam logic [3:0]  CHAR_BITS    = 4'h9;
  localparam logic [3:0]  BREAK_BITS   = 4'hd;
  localparam logic [12:0] BREAK_SHIFT  = 13'h1000;
  localparam int          RX_DEPTH     = 2;
  localparam int          TX_DEPTH     = 4;
  localparam int          RX_WIDTH     = 10;
  localparam int          TX_WIDTH     = 8;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : uart_pkg

// ---- logic/async_serial_rx_break_tx.sv ----
// serial receiver with two-entry queue, break transmitter and AHB-Lite registers
//
// How it works
// - the receiver samples the line on a 16x baud tick and moves one bit per 16 ticks.
// - a complete 8 or 9 bit character goes at once into a two-entry receive queue.
// - software sees the queue through the data register, whose read pops the oldest, and the head's status flags.
// - reception runs only with receive enable 1, sync select 0 and port enable 1.
// - a falling edge starts a character; a line still high half a bit later aborts silently.
// - each data bit is taken at its centre, one bit time apart, by majority of three samples.
// - the stop bit is sampled one bit later; a zero marks a framing error on that character.
// - after the stop bit the character is queued and the receive flag rises.
// - while overrun stands the receiver takes no new characters.
// - a break is a start bit, twelve zero bits and a stop bit.
// - with send-break and transmit enable set, the next data write starts a break.
// - send-break clears itself once the break's stop bit is out, so queued bytes follow.
// - the shift-empty status shows busy during a break just as for a character.
// - a header is send-break, dummy write, then the sync byte, sent right after the break.
// - the transmit flag shows room for a data write; software writes only while it is set.
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns

module stream_fifo
  import uart_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != CNT_FULL);
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : stream_fifo

module async_serial_rx_break_tx
  import uart_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        receive_line_pin,
  output logic             transmit_line_pin
);
  logic [5:0]      ctrl_q;
  logic            send_break_request;
  logic [15:0]     baud_div_q;
  logic [15:0]     baud_cnt_q;
  logic            tick_q;
  logic            tick_en;
  logic            ph_valid_q;
  logic            ph_write_q;
  logic [7:0]      ph_addr_q;
  logic            ph_stall;
  logic            ph_done;
  logic            bus_take;
  logic [31:0]     hrdata_q;
  logic            hreadyout_q;
  logic            hresp_q;
  logic [31:0]     rd_mux;
  logic            rx_on;
  logic            nine_bit;
  rx_state_t       rx_state_q;
  logic [3:0]      rx_cnt_q;
  logic [3:0]      rx_bits_q;
  logic [8:0]      receive_shift_reg;
  logic            maj_a_q;
  logic            maj_b_q;
  logic            line_prev_q;
  logic            maj_bit;
  logic            rx_stop_end;
  logic            rx_push;
  logic            rx_in_ready;
  logic [9:0]      rx_word;
  logic            rx_out_valid;
  logic [9:0]      receive_data_reg;
  logic            rx_pop;
  logic            overrun_q;
  logic            transmit_enable;
  logic            tx_push;
  logic            tx_in_ready;
  logic            tx_out_valid;
  logic [7:0]      tx_out_data;
  logic            tx_pop;
  logic            tx_busy_q;
  logic            tx_brk_q;
  logic [12:0]     tx_shift_q;
  logic [3:0]      tx_left_q;
  logic [3:0]      tx_cnt_q;
  logic            tx_line_q;
  logic            tx_done;

  assign hrdata             = hrdata_q;
  assign hreadyout          = hreadyout_q;
  assign hresp              = hresp_q;
  assign transmit_line_pin  = tx_line_q;
  assign transmit_enable    = ctrl_q[CTRL_TRANSMIT_ENABLE];
  assign nine_bit           = ctrl_q[CTRL_NINE];
  assign rx_on = ctrl_q[CTRL_SERIAL_PORT_ENABLE] && ctrl_q[CTRL_RECEIVE_CONTINUOUS_ENABLE] && !ctrl_q[CTRL_SYNC];
  assign tick_en = ce && tick_q;

  // 16x tick shared by both directions
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      baud_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (ce)
    begin
      tick_q     <= (baud_cnt_q >= baud_div_q);
      baud_cnt_q <= (baud_cnt_q >= baud_div_q) ? '0 : baud_cnt_q + 1'b1;
    end
  end

  // bus slave: every transfer has at least one wait state so hrdata comes from a flop
  assign bus_take = hsel && htrans[1] && hready;
  assign ph_stall = ph_write_q && (ph_addr_q == ADDR_TXDATA) && transmit_enable && !tx_in_ready;
  assign ph_done  = ph_valid_q && !ph_stall;

  always_comb
  begin
    rd_mux = '0;
    unique case (ph_addr_q)
      ADDR_CTRL:   rd_mux = {26'h0, ctrl_q[5], send_break_request, ctrl_q[3:0]};
      ADDR_STATUS: rd_mux = {25'h0, send_break_request,
                             rx_out_valid && receive_data_reg[8],
                             rx_out_valid && receive_data_reg[9],
                             overrun_q, !tx_busy_q, tx_in_ready, rx_out_valid};
      ADDR_RXDATA: rd_mux = rx_out_valid ? {22'h0, receive_data_reg} : 32'h0;
      ADDR_BAUD:   rd_mux = {16'h0, baud_div_q};
      default:     rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph_valid_q  <= 1'b0;
      ph_write_q  <= 1'b0;
      ph_addr_q   <= '0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= '0;
      hresp_q     <= 1'b0;
    end
    else if (ce)
    begin
      hresp_q <= 1'b0;
      if (bus_take)
      begin
        ph_valid_q  <= 1'b1;
        ph_write_q  <= hwrite;
        ph_addr_q   <= haddr[7:0];
        hreadyout_q <= 1'b0;
      end
      else if (ph_done)
      begin
        ph_valid_q  <= 1'b0;
        hreadyout_q <= 1'b1;
        hrdata_q    <= ph_write_q ? 32'h0 : rd_mux;
      end
    end
  end

  // control, baud and send-break
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q             <= CTRL_RESET;
      send_break_request <= 1'b0;
      baud_div_q         <= BAUD_RESET;
    end
    else if (ce)
    begin
      if (ph_done && ph_write_q && ph_addr_q == ADDR_CTRL)
      begin
        ctrl_q             <= hwdata[5:0];
        send_break_request <= hwdata[CTRL_SEND_BREAK_REQUEST];
      end
      else if (tx_done && tx_brk_q)
      begin
        send_break_request <= 1'b0;
      end
      if (ph_done && ph_write_q && ph_addr_q == ADDR_BAUD)
      begin
        baud_div_q <= hwdata[15:0];
      end
    end
  end

  // receiver
  assign maj_bit     = (maj_a_q & maj_b_q) | (maj_a_q & receive_line_pin) |
                       (maj_b_q & receive_line_pin);
  assign rx_stop_end = rx_on && tick_en && rx_state_q == RX_STOP && rx_cnt_q == TICK_LAST;
  assign rx_push     = rx_stop_end && rx_in_ready;
  assign rx_word     = nine_bit ? {!maj_bit, receive_shift_reg[8], receive_shift_reg[7:0]}
                                : {!maj_bit, 1'b0, receive_shift_reg[8:1]};
  assign rx_pop      = ph_done && !ph_write_q && ph_addr_q == ADDR_RXDATA;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_state_q        <= RX_IDLE;
      rx_cnt_q          <= '0;
      rx_bits_q         <= '0;
      receive_shift_reg <= '0;
      maj_a_q           <= 1'b1;
      maj_b_q           <= 1'b1;
      line_prev_q       <= 1'b1;
    end
    else if (ce && !rx_on)
    begin
      rx_state_q <= RX_IDLE;
    end
    else if (tick_en)
    begin
      line_prev_q <= receive_line_pin;
      rx_cnt_q    <= rx_cnt_q + 1'b1;
      if (rx_cnt_q == MAJ_FIRST)
      begin
        maj_a_q <= receive_line_pin;
      end
      if (rx_cnt_q == MAJ_SECOND)
      begin
        maj_b_q <= receive_line_pin;
      end
      unique case (rx_state_q)
        RX_IDLE:
        begin
          rx_cnt_q <= '0;
          if (!overrun_q && line_prev_q && !receive_line_pin)
          begin
            rx_state_q <= RX_START;
          end
        end
        RX_START:
        begin
          if (rx_cnt_q == HALF_BIT)
          begin
            rx_cnt_q   <= '0;
            rx_bits_q  <= '0;
            rx_state_q <= receive_line_pin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_cnt_q == TICK_LAST)
          begin
            receive_shift_reg <= {maj_bit, receive_shift_reg[8:1]};
            rx_bits_q         <= rx_bits_q + 1'b1;
            if (rx_bits_q == (nine_bit ? LAST_BIT_9 : LAST_BIT_8))
            begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (rx_cnt_q == TICK_LAST)
          begin
            rx_state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // overrun: a full queue drops the new character; cleared by dropping receive enable
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      overrun_q <= 1'b0;
    end
    else if (ce)
    begin
      if (rx_stop_end && !rx_in_ready)
      begin
        overrun_q <= 1'b1;
      end
      else if (!ctrl_q[CTRL_RECEIVE_CONTINUOUS_ENABLE])
      begin
        overrun_q <= 1'b0;
      end
    end
  end

  stream_fifo #(.WIDTH(RX_WIDTH), .DEPTH(RX_DEPTH)) rx_queue (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (rx_word),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (receive_data_reg)
  );

  // transmitter; a write while disabled is dropped, while full it stalls the bus
  assign tx_push = ph_done && ph_write_q && ph_addr_q == ADDR_TXDATA && transmit_enable;
  assign tx_pop  = transmit_enable && tick_en && !tx_busy_q && tx_out_valid;
  assign tx_done = transmit_enable && tick_en && tx_busy_q && tx_cnt_q == TICK_LAST &&
                   tx_left_q == '0;

  stream_fifo #(.WIDTH(TX_WIDTH), .DEPTH(TX_DEPTH)) tx_queue (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (hwdata[7:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_out_data)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_busy_q  <= 1'b0;
      tx_brk_q   <= 1'b0;
      tx_shift_q <= '0;
      tx_left_q  <= '0;
      tx_cnt_q   <= '0;
      tx_line_q  <= 1'b1;
    end
    else if (ce && !transmit_enable)
    begin
      tx_busy_q <= 1'b0;
      tx_line_q <= 1'b1;
    end
    else if (tx_pop)
    begin
      // send-break is judged when a byte leaves the queue, so the sync byte behind it
      // goes out as data once the flag has cleared
      tx_busy_q  <= 1'b1;
      tx_brk_q   <= send_break_request;
      tx_shift_q <= send_break_request ? BREAK_SHIFT : {5'h1f, tx_out_data};
      tx_left_q  <= send_break_request ? BREAK_BITS : CHAR_BITS;
      tx_cnt_q   <= '0;
      tx_line_q  <= 1'b0;
    end
    else if (tick_en && tx_busy_q)
    begin
      tx_cnt_q <= tx_cnt_q + 1'b1;
      if (tx_cnt_q == TICK_LAST)
      begin
        if (tx_left_q == '0)
        begin
          tx_busy_q <= 1'b0;
        end
        else
        begin
          tx_line_q  <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[12:1]};
          tx_left_q  <= tx_left_q - 1'b1;
        end
      end
    end
  end

  rx_tick_only_a: assert property (@(posedge clk) disable iff (!nrst)
    (rx_state_q == RX_DATA && rx_cnt_q != $past(rx_cnt_q)) |-> $past(tick_en))
    else $error("receive bit counter moved without a tick");

  rx_enable_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !rx_on) |=> rx_state_q == RX_IDLE)
    else $error("receiver active while not enabled");

  start_abort_a: assert property (@(posedge clk) disable iff (!nrst)
    (rx_on && tick_en && rx_state_q == RX_START && rx_cnt_q == HALF_BIT && receive_line_pin)
    |=> rx_state_q == RX_IDLE && !overrun_q == !$past(overrun_q))
    else $error("false start bit not abandoned");

  frame_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    rx_push |-> rx_word[9] == !(maj_a_q ? (maj_b_q | receive_line_pin)
                                        : (maj_b_q & receive_line_pin)))
    else $error("framing error does not follow stop sample");

  rx_queue_push_a: assert property (@(posedge clk) disable iff (!nrst)
    (rx_stop_end && rx_in_ready) |=> rx_out_valid)
    else $error("finished character not queued");

  overrun_set_a: assert property (@(posedge clk) disable iff (!nrst)
    (rx_stop_end && !rx_in_ready) |=> overrun_q && rx_queue.count_q <= $past(rx_queue.count_q))
    else $error("overrun not raised on full queue");

  overrun_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (overrun_q && rx_state_q == RX_IDLE && rx_on) |=> rx_state_q == RX_IDLE)
    else $error("receiver started during overrun");

  break_start_a: assert property (@(posedge clk) disable iff (!nrst)
    (tx_pop && send_break_request) |=> !tx_line_q && tx_left_q == BREAK_BITS && tx_brk_q)
    else $error("break not loaded as zeros");

  break_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (tx_done && tx_brk_q && !(ph_done && ph_write_q && ph_addr_q == ADDR_CTRL))
    |=> !send_break_request && !tx_busy_q)
    else $error("send-break not cleared after break");

  pop_on_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && rx_out_valid && !rx_push && !rx_pop) |=> rx_out_valid)
    else $error("receive queue lost an entry without a read");
endmodule : async_serial_rx_break_tx

// ---- test/remote_node.sv ----
// remote serial node model: drives the receive line and decodes the transmit line
`timescale 1ns/1ns

module remote_node #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  // decoded frames: bit 8 marks a break, low byte the data
  logic [8:0] got_q[$];

  // idle line is high, as for a released line with pull-up
  initial rx_line = 1'b1;

  // start bit, nbits lsb first, then the given stop level
  task automatic send_char(input logic [8:0] data, input int nbits, input logic stop);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nbits; i++)
    begin
      rx_line <= data[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rx_line <= stop;
    repeat (BIT_CLKS) @(posedge clk);
    rx_line <= 1'b1;
  endtask : send_char

  // low pulse far shorter than half a bit
  task automatic glitch(input int n);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (n) @(posedge clk);
    rx_line <= 1'b1;
  endtask : glitch

  // samples at bit centres; an all-zero frame runs on to look for a break
  always
  begin : decode
    logic [12:0] b;
    b = 13'h1fff;
    @(negedge tx_line);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 13; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk);
      b[i] = tx_line;
      if (i == 8 && b[8:0] != 9'h000)
        break;
    end
    if (b[8:0] == 9'h000)
      got_q.push_back({b[12:9] == 4'h8, 8'h00});
    else
      got_q.push_back({1'b0, b[7:0]});
  end
endmodule : remote_node

// ---- test/tb_async_serial_rx_break_tx.sv ----
// self-checking bench: register bus tasks plus serial traffic through the partner node
`timescale 1ns/1ns
`define CHECK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb_async_serial_rx_break_tx
  import uart_pkg::*;
();
  // baud register 1 gives a tick every 2 clocks, so 32 clocks a bit
  localparam int BIT = 32;
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rxl;
  logic        txl;
  logic [2:0]  cfg [3];
  int          fails;
  int          checks_done;
  int          cycles = 0;

  assign hready = hreadyout;

  async_serial_rx_break_tx dut (
    .clk               (clk),
    .nrst              (nrst),
    .ce                (ce),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hready),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .receive_line_pin  (rxl),
    .transmit_line_pin (txl)
  );

  remote_node #(.BIT_CLKS(BIT)) node (
    .clk     (clk),
    .tx_line (txl),
    .rx_line (rxl)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fails++;
      summarize();
    end
  end

  // one single transfer: address phase, then data phase, each held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    `CHECK("hresp", 1'b0, hresp)
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    `CHECK(nm, exp, d)
  endtask : rdc

  task automatic chk_st(input int b, input logic exp, input string nm);
    logic [31:0] d;
    bus(1'b0, ADDR_STATUS, 32'h0, d);
    `CHECK(nm, exp, d[b])
  endtask : chk_st

  task automatic expect_tx(input logic [8:0] exp);
    logic [8:0] f;
    int n;
    n = 0;
    f = 9'h1ff;
    while (node.got_q.size() == 0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (node.got_q.size() > 0)
      f = node.got_q.pop_front();
    `CHECK("tx frame", exp, f)
  endtask : expect_tx

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fails = 0;
    checks_done = 0;
    cfg = '{3'h2, 3'h1, 3'h7};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHECK("tx idle", 1'b1, txl)
    rdc(ADDR_CTRL, 32'h0, "ctrl");
    rdc(ADDR_BAUD, 32'h36, "baud");
    rdc(ADDR_STATUS, 32'h6, "status");
    wr(8'h14, 32'hffffffff);
    rdc(8'h14, 32'h0, "unmapped");
    wr(ADDR_BAUD, 32'h1);
    rdc(ADDR_BAUD, 32'h1, "baud");
    // each enable condition missing in turn
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_CTRL, {29'h0, cfg[i]});
      node.send_char(9'h05a, 8, 1'b1);
      chk_st(ST_RXIF, 1'b0, "rx off");
    end
    wr(ADDR_CTRL, 32'h3);
    node.glitch(6);
    repeat (2 * BIT) @(posedge clk);
    chk_st(ST_RXIF, 1'b0, "glitch");
    node.send_char(9'h0a5, 8, 1'b1);
    node.send_char(9'h03c, 8, 1'b0);
    chk_st(ST_RXIF, 1'b1, "rxif");
    chk_st(ST_FERR, 1'b0, "ferr head");
    rdc(ADDR_RXDATA, 32'h0a5, "rx first");
    chk_st(ST_FERR, 1'b1, "ferr head");
    rdc(ADDR_RXDATA, 32'h23c, "rx ferr");
    rdc(ADDR_RXDATA, 32'h0, "rx empty");
    wr(ADDR_CTRL, 32'h23);
    node.send_char(9'h1c3, 9, 1'b1);
    chk_st(ST_BIT9, 1'b1, "bit9 head");
    rdc(ADDR_RXDATA, 32'h1c3, "rx nine");
    wr(ADDR_CTRL, 32'h3);
    node.send_char(9'h001, 8, 1'b1);
    node.send_char(9'h002, 8, 1'b1);
    node.send_char(9'h003, 8, 1'b1);
    chk_st(ST_OVERRUN, 1'b1, "overrun");
    rdc(ADDR_RXDATA, 32'h001, "rx q0");
    rdc(ADDR_RXDATA, 32'h002, "rx q1");
    node.send_char(9'h004, 8, 1'b1);
    chk_st(ST_RXIF, 1'b0, "held off");
    wr(ADDR_CTRL, 32'h1);
    chk_st(ST_OVERRUN, 1'b0, "overrun clr");
    wr(ADDR_CTRL, 32'h3);
    node.send_char(9'h011, 8, 1'b1);
    rdc(ADDR_RXDATA, 32'h011, "rx resume");
    // a frozen receiver must miss a character sent while the enable is low
    ce <= 1'b0;
    node.send_char(9'h066, 8, 1'b1);
    ce <= 1'b1;
    chk_st(ST_RXIF, 1'b0, "ce freeze");
    wr(ADDR_CTRL, 32'h9);
    wr(ADDR_TXDATA, 32'h96);
    repeat (3 * BIT) @(posedge clk);
    chk_st(ST_TSE, 1'b0, "tse busy");
    expect_tx(9'h096);
    repeat (2 * BIT) @(posedge clk);
    chk_st(ST_TSE, 1'b1, "tse idle");
    // header: break from a dummy byte, then the sync byte
    wr(ADDR_CTRL, 32'h19);
    wr(ADDR_TXDATA, 32'hff);
    wr(ADDR_TXDATA, 32'h55);
    chk_st(ST_SEND_BREAK_REQUEST, 1'b1, "send_break_request set");
    repeat (2 * BIT) @(posedge clk);
    chk_st(ST_TSE, 1'b0, "tse break");
    expect_tx(9'h100);
    expect_tx(9'h055);
    repeat (2 * BIT) @(posedge clk);
    rdc(ADDR_CTRL, 32'h9, "send_break_request clr");
    chk_st(ST_TSE, 1'b1, "tse done");
    // one byte in the shifter and four queued leaves no room
    for (int i = 0; i < 5; i++)
      wr(ADDR_TXDATA, 32'h30 + i);
    chk_st(ST_TXIF, 1'b0, "txif full");
    for (int i = 0; i < 5; i++)
      expect_tx(9'h030 + i[8:0]);
    chk_st(ST_TXIF, 1'b1, "txif room");
    summarize();
  end
endmodule : tb_async_serial_rx_break_tx
